// file: design/alarm_fail_status.sv
// alarm, fault routing and status word of the temperature converter
`timescale 1ns/1ns

// Summary of operation
// R1: four alarm modes, two thresholds, hysteresis
// R2: high mode clears below threshold minus hysteresis
// R3: low mode clears above threshold plus hysteresis
// R4: inside band: hysteresis applied outward
// R5: outside band: hysteresis applied inward
// R6: alarm routed to contact, analog, or both
// R7: analog forced to 21mA or 10.5V
// R8: each fault source enables the contact; the sensor fault has no contact enable, only the other six sources do
// R9: config bit picks contact state on alarm
// R10: contact starts open unless closed chosen
// R11: alarm may follow digital input level
// R12: 16-bit status word readable by register
// R13: status bits in documented order
// R14: input type register holds sensor code
// R15: bit 0 voltage/current, bits 1-2 source
// R16: bits 3-9 enable analog fault forcing
// R17: bits 10-11 threshold mode, 12 manual
// R18: manual mode drives outputs from registers
// R19: writable output value register for manual
// R20: evaluate and update on every sample
// R21: global fault is OR of fault bits
module alarm_fail_status
  import alarm_fail_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire reg_req_t i_reg_req,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_ack,
  input wire logic i_sample_valid,
  input wire logic [15:0] i_sample,
  input wire logic [15:0] i_scaled_out,
  input wire fault_in_t i_fault,
  input wire logic i_din,
  output logic o_dout,
  output logic o_ao_force,
  output logic o_ao_voltage,
  output logic [15:0] o_ao_value,
  output logic [15:0] o_status
);

  // true when the request writes the given address
  function automatic logic wr_hit(input reg_req_t r, input logic [15:0] a);
    return r.wr && (r.addr == a);
  endfunction : wr_hit

  // software registers
  logic [15:0] sensor_type_reg; // sensor code
  logic [15:0] out_cfg_reg; // output configuration
  logic [15:0] out_value_reg; // manual analog level
  logic [15:0] thr_high_reg; // upper threshold
  logic [15:0] thr_low_reg; // lower threshold
  logic [15:0] hyst_reg; // hysteresis, unsigned
  logic [15:0] alarm_ctrl_reg; // routing and contact setup
  logic manual_do_reg; // manual contact state

  // evaluation state
  logic alarm_reg; // threshold alarm held between samples
  logic seen_reg; // a sample has been evaluated
  logic [15:0] status_reg; // machine status word
  logic dout_reg; // contact closed when high
  logic ao_force_reg; // analog forced to fault level
  logic ao_volt_reg; // analog runs in voltage mode
  logic [15:0] ao_value_reg; // analog level in mV or uA
  logic [15:0] rdata_reg; // read answer
  logic ack_reg; // read answer strobe

  // R17: field decode of the output configuration
  wire thr_mode_t mode = thr_mode_t'(out_cfg_reg[CFG_MODE_LSB +: 2]);
  wire logic manual = out_cfg_reg[CFG_MANUAL];
  // R15: bit 0 clear means voltage output
  wire logic volt_mode = ~out_cfg_reg[CFG_CURRENT];
  // source select bits 1-2 steer the front end; this block only stores and reads them back
  wire logic [6:0] ao_fen = out_cfg_reg[CFG_FEN_LSB +: 7];

  // alarm control field decode
  wire logic route_do = alarm_ctrl_reg[ACTL_ROUTE_DO];
  wire logic closed_on = alarm_ctrl_reg[ACTL_CLOSED_ON];
  wire logic init_closed = alarm_ctrl_reg[ACTL_INIT_CLOSED];
  wire logic din_en = alarm_ctrl_reg[ACTL_DIN_EN];
  wire logic din_level = alarm_ctrl_reg[ACTL_DIN_LEVEL];
  wire logic [5:0] do_fen = alarm_ctrl_reg[ACTL_FEN_LSB +: 6];

  // threshold comparison against the new sample
  logic thr_next;
  alarm_threshold_cmp u_cmp (
    .i_mode(mode),
    .i_value(i_sample),
    .i_upper(thr_high_reg),
    .i_lower(thr_low_reg),
    .i_hyst(hyst_reg),
    .i_alarm_prev(alarm_reg),
    .o_alarm_next(thr_next)
  );

  // R11: alarm may follow a chosen digital input level
  wire logic din_alarm = din_en && (i_din == din_level);
  wire logic alarm_any = thr_next | din_alarm;

  // R8: contact fault sources, each gated by its own enable
  wire logic [5:0] do_src = {i_fault.eeprom, i_fault.rtc, i_fault.logging,
                             i_fault.hw, i_fault.over, i_fault.under};
  // R6: contact route enable
  wire logic do_active = (alarm_any & route_do) | (|(do_src & do_fen));
  // R9: contact state while active, the opposite when idle
  wire logic dout_auto = do_active ? closed_on : ~closed_on;

  // R16: analog forcing sources, bit 9 doubles as the analog alarm route
  wire logic [6:0] ao_src = {alarm_any, i_fault.eeprom, i_fault.rtc,
                             i_fault.logging, i_fault.hw, i_fault.over, i_fault.under};
  // R6: analog route is the alarm enable of bits 3-9
  wire logic ao_force_auto = |(ao_src & ao_fen);
  // R7: fault level depends on voltage or current mode
  wire logic [15:0] fault_level = volt_mode ? FAULT_LEVEL_MV : FAULT_LEVEL_UA;

  // R18: manual mode bypasses tracking and fault forcing
  wire logic dout_next = manual ? manual_do_reg : dout_auto;
  wire logic ao_force_next = ~manual & ao_force_auto;
  wire logic [15:0] ao_value_next = manual ? out_value_reg :
                                    ao_force_auto ? fault_level : i_scaled_out;

  // R21: global fault gathers the hw, logging, rtc, eeprom and sensor fault bits
  wire logic global_fault = i_fault.hw | i_fault.logging | i_fault.rtc |
                            i_fault.eeprom | i_fault.sensor;
  // R13: status word layout, top bits read zero
  wire logic [15:0] status_next = {5'h00, i_fault.sensor, i_fault.eeprom,
                                   i_fault.rtc, i_fault.logging, i_fault.hw,
                                   dout_next, i_din, i_fault.under, i_fault.over,
                                   alarm_any, global_fault};

  // R12: read decode, unmapped words answer zero
  wire logic [15:0] rdata_next =
    (i_reg_req.addr == ADDR_SENSOR_TYPE) ? sensor_type_reg :
    (i_reg_req.addr == ADDR_OUT_CFG) ? out_cfg_reg :
    (i_reg_req.addr == ADDR_STATUS) ? status_reg :
    (i_reg_req.addr == ADDR_OUT_VALUE) ? out_value_reg :
    (i_reg_req.addr == ADDR_THR_HIGH) ? thr_high_reg :
    (i_reg_req.addr == ADDR_THR_LOW) ? thr_low_reg :
    (i_reg_req.addr == ADDR_HYST) ? hyst_reg :
    (i_reg_req.addr == ADDR_ALARM_CTRL) ? alarm_ctrl_reg :
    (i_reg_req.addr == ADDR_MANUAL_DO) ? {15'h0000, manual_do_reg} : RST_WORD;

  // register writes; the status word is read-only so a write is dropped
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sensor_type_reg <= RST_SENSOR_TYPE;
      out_cfg_reg <= RST_OUT_CFG;
      out_value_reg <= RST_WORD;
      thr_high_reg <= RST_WORD;
      thr_low_reg <= RST_WORD;
      hyst_reg <= RST_WORD;
      alarm_ctrl_reg <= RST_WORD;
      manual_do_reg <= 1'b0;
    end else begin
      // R14: sensor code stored as written
      if (wr_hit(i_reg_req, ADDR_SENSOR_TYPE)) begin
        sensor_type_reg <= i_reg_req.wdata;
      end
      // R15: output configuration word
      if (wr_hit(i_reg_req, ADDR_OUT_CFG)) begin
        out_cfg_reg <= i_reg_req.wdata;
      end
      // R19: output value written by the remote master
      if (wr_hit(i_reg_req, ADDR_OUT_VALUE)) begin
        out_value_reg <= i_reg_req.wdata;
      end
      if (wr_hit(i_reg_req, ADDR_THR_HIGH)) begin
        thr_high_reg <= i_reg_req.wdata;
      end
      if (wr_hit(i_reg_req, ADDR_THR_LOW)) begin
        thr_low_reg <= i_reg_req.wdata;
      end
      if (wr_hit(i_reg_req, ADDR_HYST)) begin
        hyst_reg <= i_reg_req.wdata;
      end
      if (wr_hit(i_reg_req, ADDR_ALARM_CTRL)) begin
        alarm_ctrl_reg <= i_reg_req.wdata;
      end
      if (wr_hit(i_reg_req, ADDR_MANUAL_DO)) begin
        manual_do_reg <= i_reg_req.wdata[0];
      end
    end
  end

  // R20: alarm state and status word move only on a sample
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      alarm_reg <= 1'b0;
      seen_reg <= 1'b0;
      status_reg <= RST_WORD;
    end else if (i_sample_valid) begin
      alarm_reg <= thr_next;
      seen_reg <= 1'b1;
      status_reg <= status_next;
    end
  end

  // outputs: sample step in auto mode, every cycle in manual mode
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      dout_reg <= 1'b0;
      ao_force_reg <= 1'b0;
      ao_value_reg <= RST_WORD;
    end else if (i_sample_valid || manual) begin
      dout_reg <= dout_next;
      ao_force_reg <= ao_force_next;
      ao_value_reg <= ao_value_next;
    end else if (!seen_reg) begin
      // R10: before any sample the contact shows its start state
      dout_reg <= init_closed;
    end
  end

  // mode flag follows the configuration every cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ao_volt_reg <= 1'b1;
    end else begin
      ao_volt_reg <= volt_mode;
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rdata_reg <= RST_WORD;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= i_reg_req.rd;
      if (i_reg_req.rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_ack = ack_reg;
  assign o_dout = dout_reg;
  assign o_ao_force = ao_force_reg;
  assign o_ao_voltage = ao_volt_reg;
  assign o_ao_value = ao_value_reg;
  assign o_status = status_reg;

  // ---- checks ----
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // signed views used by the hysteresis checks
  wire logic signed [17:0] s_v = {{2{i_sample[15]}}, i_sample};
  wire logic signed [17:0] s_up = {{2{thr_high_reg[15]}}, thr_high_reg};
  wire logic signed [17:0] s_lo = {{2{thr_low_reg[15]}}, thr_low_reg};
  wire logic signed [17:0] s_hy = {2'b00, hyst_reg};

  // one automatic evaluation step
  sequence s_auto_step;
    i_sample_valid && !manual;
  endsequence

  // a held alarm seeing a new sample in a given mode
  sequence s_held(thr_mode_t m);
    i_sample_valid && alarm_reg && mode == m;
  endsequence

  // R2: release below threshold minus hysteresis
  a_high_release: assert property ( // R2
    s_held(MODE_HIGH) ##0 (s_v < s_up - s_hy) |=> !alarm_reg)
    else $error("high alarm not released");

  // R3: release above threshold plus hysteresis
  a_low_release: assert property ( // R3
    s_held(MODE_LOW) ##0 (s_v > s_lo + s_hy) |=> !alarm_reg)
    else $error("low alarm not released");

  // R4: held while within the widened band
  a_inside_hold: assert property ( // R4
    s_held(MODE_INSIDE) ##0 (s_v >= s_lo - s_hy && s_v <= s_up + s_hy)
    |=> alarm_reg)
    else $error("inside alarm dropped early");

  // R5: held until deep enough inside the band
  a_outside_hold: assert property ( // R5
    s_held(MODE_OUTSIDE) ##0 (s_v >= s_up - s_hy || s_v <= s_lo + s_hy)
    |=> alarm_reg)
    else $error("outside alarm dropped early");

  // R7: forced analog level follows the output mode
  a_ao_fault_level: assert property ( // R7
    s_auto_step ##0 ao_force_auto
    |=> o_ao_force && o_ao_value == $past(fault_level))
    else $error("analog fault level wrong");

  // R9: contact state while active
  a_dout_polarity: assert property ( // R9
    s_auto_step ##0 do_active |=> o_dout == $past(closed_on))
    else $error("contact polarity wrong");

  // R10: start state held until the first sample
  a_initial_state: assert property ( // R10
    !seen_reg && !i_sample_valid && !manual |=> o_dout == $past(init_closed))
    else $error("contact start state wrong");

  // R18: manual mode copies the written level
  a_manual_drive: assert property ( // R18
    manual |=> !o_ao_force && o_ao_value == $past(out_value_reg))
    else $error("manual output not applied");

  // R20: status stands still between samples
  a_status_stable: assert property ( // R20
    !i_sample_valid |=> $stable(o_status))
    else $error("status moved without sample");

  // R21: global bit tracks the fault bits
  a_global_fault: assert property ( // R21
    o_status[ST_GLOBAL] == |o_status[ST_SENSOR:ST_HW])
    else $error("global fault bit mismatch");

  // R12: status read returns the held word next cycle
  a_status_read: assert property ( // R12
    i_reg_req.rd && i_reg_req.addr == ADDR_STATUS
    |=> o_reg_ack && o_reg_rdata == $past(o_status))
    else $error("status read wrong");

  // R4: released once beyond the widened band
  a_inside_release: assert property ( // R4
    s_held(MODE_INSIDE) ##0 (s_v < s_lo - s_hy || s_v > s_up + s_hy)
    |=> !alarm_reg)
    else $error("inside alarm not released");

  // R5: released once deep inside the band
  a_outside_release: assert property ( // R5
    s_held(MODE_OUTSIDE) ##0 (s_v < s_up - s_hy && s_v > s_lo + s_hy)
    |=> !alarm_reg)
    else $error("outside alarm not released");

  // R2: held at and above threshold minus hysteresis
  a_high_hold: assert property ( // R2
    s_held(MODE_HIGH) ##0 (s_v >= s_up - s_hy) |=> alarm_reg)
    else $error("high alarm dropped early");

  // R3: held at and below threshold plus hysteresis
  a_low_hold: assert property ( // R3
    s_held(MODE_LOW) ##0 (s_v <= s_lo + s_hy) |=> alarm_reg)
    else $error("low alarm dropped early");

  // R1: crossing the upper threshold sets the high alarm
  a_high_set: assert property ( // R1
    i_sample_valid && mode == MODE_HIGH && s_v > s_up |=> alarm_reg)
    else $error("high alarm not set");

  // R11: the chosen input level raises the status alarm bit
  a_din_alarm: assert property ( // R11
    i_sample_valid && din_en && i_din == din_level |=> o_status[ST_ALARM])
    else $error("input level alarm missing");

endmodule : alarm_fail_status

// file: design/alarm_fail_pkg.sv
// constants and types shared by the alarm and fault evaluation block
package alarm_fail_pkg;

  // register word addresses on the serial register map
  localparam logic [15:0] ADDR_SENSOR_TYPE = 16'h0065;
  localparam logic [15:0] ADDR_OUT_CFG = 16'h006A;
  localparam logic [15:0] ADDR_STATUS = 16'h9C45;
  localparam logic [15:0] ADDR_OUT_VALUE = 16'h0008;
  localparam logic [15:0] ADDR_THR_HIGH = 16'h0070;
  localparam logic [15:0] ADDR_THR_LOW = 16'h0071;
  localparam logic [15:0] ADDR_HYST = 16'h0072;
  localparam logic [15:0] ADDR_ALARM_CTRL = 16'h0073;
  localparam logic [15:0] ADDR_MANUAL_DO = 16'h0074;

  // reset values
  localparam logic [15:0] RST_SENSOR_TYPE = 16'h0002;
  localparam logic [15:0] RST_OUT_CFG = 16'h0000;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // output configuration fields
  localparam int CFG_CURRENT = 0;
  localparam int CFG_SRC_LSB = 1;
  localparam int CFG_FEN_LSB = 3;
  localparam int CFG_MODE_LSB = 10;
  localparam int CFG_MANUAL = 12;

  // alarm control fields
  localparam int ACTL_ROUTE_DO = 0;
  localparam int ACTL_CLOSED_ON = 1;
  localparam int ACTL_INIT_CLOSED = 2;
  localparam int ACTL_DIN_EN = 3;
  localparam int ACTL_DIN_LEVEL = 4;
  localparam int ACTL_FEN_LSB = 8;

  // machine status word bit positions
  localparam int ST_GLOBAL = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_OVER = 2;
  localparam int ST_UNDER = 3;
  localparam int ST_DIN = 4;
  localparam int ST_DOUT = 5;
  localparam int ST_HW = 6;
  localparam int ST_SENSOR = 10;

  // forced analog levels: 21000 uA and 10500 mV
  localparam logic [15:0] FAULT_LEVEL_UA = 16'h5208;
  localparam logic [15:0] FAULT_LEVEL_MV = 16'h2904;

  typedef enum logic [1:0] {MODE_HIGH, MODE_LOW, MODE_INSIDE, MODE_OUTSIDE} thr_mode_t;

  // fault sources from the measurement and system logic
  typedef struct packed {
    logic sensor;
    logic eeprom;
    logic rtc;
    logic logging;
    logic hw;
    logic over;
    logic under;
  } fault_in_t;

  // one register request from the serial link decoder
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

endpackage : alarm_fail_pkg

// file: design/alarm_threshold_cmp.sv
// threshold comparator with hysteresis for the four alarm modes
`timescale 1ns/1ns
module alarm_threshold_cmp
  import alarm_fail_pkg::*;
(
  input wire thr_mode_t i_mode,
  input wire logic [15:0] i_value,
  input wire logic [15:0] i_upper,
  input wire logic [15:0] i_lower,
  input wire logic [15:0] i_hyst,
  input wire logic i_alarm_prev,
  output logic o_alarm_next
);
  // 18 bits so threshold minus hysteresis cannot wrap
  wire logic signed [17:0] v = {{2{i_value[15]}}, i_value};
  wire logic signed [17:0] up = {{2{i_upper[15]}}, i_upper};
  wire logic signed [17:0] lo = {{2{i_lower[15]}}, i_lower};
  wire logic signed [17:0] hy = {2'b00, i_hyst};
  wire logic signed [17:0] up_in = up - hy;
  wire logic signed [17:0] up_out = up + hy;
  wire logic signed [17:0] lo_in = lo + hy;
  wire logic signed [17:0] lo_out = lo - hy;

  // R2: high mode releases below threshold minus hysteresis
  wire logic hi_al = i_alarm_prev ? (v >= up_in) : (v > up);
  // R3: low mode releases above threshold plus hysteresis
  wire logic lo_al = i_alarm_prev ? (v <= lo_in) : (v < lo);
  // R4: inside band, hysteresis widens the band outward
  wire logic in_al = i_alarm_prev ? (v >= lo_out && v <= up_out) : (v >= lo && v <= up);
  // R5: outside band, hysteresis narrows the band inward
  // a held alarm stays on at the inner limits themselves, release needs more than the hysteresis
  wire logic out_al = i_alarm_prev ? (v >= up_in || v <= lo_in) : (v > up || v < lo);

  // R1: mode selects one of the four comparisons
  assign o_alarm_next = (i_mode == MODE_HIGH) ? hi_al :
                        (i_mode == MODE_LOW) ? lo_al :
                        (i_mode == MODE_INSIDE) ? in_al : out_al;

endmodule : alarm_threshold_cmp

// file: verif/field_stage.sv
// behavioural field side: contact, analog load and the digital input line
`timescale 1ns/1ns
module field_stage
  import alarm_fail_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_contact,
  input wire logic i_force,
  input wire logic i_voltage,
  input wire logic [15:0] i_level,
  input wire logic i_din_req,
  output logic o_din,
  output logic o_relay,
  output logic [15:0] o_load
);
  // the digital input is a plain level from the field, no debounce modelled
  assign o_din = i_din_req;
  // load seen by the field: voltage mode reads mV, current mode reads uA
  always_ff @(posedge i_ref_clk) begin
    // a forced level is held as the loop sees it, the contact gates nothing here
    o_load <= i_force ? (i_voltage ? FAULT_LEVEL_MV : FAULT_LEVEL_UA) : i_level;
    // the relay wiring follows the contact one clock late, like the load
    o_relay <= i_contact;
  end
endmodule : field_stage

// file: verif/tb.sv
// self-checking testbench of the alarm and fault evaluation block
`timescale 1ns/1ns
module tb;
  import alarm_fail_pkg::*;
  logic i_ref_clk;
  logic i_rst_n;
  reg_req_t req; // register request driven by the bench
  logic valid;
  logic [15:0] sample;
  logic [15:0] scaled;
  fault_in_t fault;
  logic din_req; // digital input level asked of the field model
  logic din;
  logic [15:0] rdata;
  logic ack;
  logic dout;
  logic ao_force;
  logic ao_voltage;
  logic [15:0] ao_value;
  logic [15:0] status;
  logic [15:0] load;
  logic relay; // contact as the field wiring sees it
  int bad_count;
  int checked;
  int cycles = 0;
  integer seed;
  logic alarm_exp; // expected threshold alarm state, tracks hysteresis
  logic [15:0] cfg, actl, upper, lower, hyst, st_exp;
  logic [15:0] codes [4] = '{16'h0002, 16'h0003, 16'h0015, 16'h001C};
  int corner [10] = '{101, 100, 80, 79, -101, -100, -80, -79, 0, 121};

  alarm_fail_status dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_reg_ack(ack), .i_sample_valid(valid), .i_sample(sample), .i_scaled_out(scaled), .i_fault(fault),
    .i_din(din), .o_dout(dout), .o_ao_force(ao_force), .o_ao_voltage(ao_voltage), .o_ao_value(ao_value),
    .o_status(status));
  field_stage u_field (.i_ref_clk(i_ref_clk), .i_contact(dout), .i_force(ao_force), .i_voltage(ao_voltage),
    .i_level(ao_value), .i_din_req(din_req), .o_din(din), .o_relay(relay), .o_load(load));

  // free-running 100 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      final_report();
    end
  end

  // alarm next state from the rules, signed values in int to avoid wrap
  function automatic logic thr_next(logic [1:0] m, logic [15:0] v16, logic prev);
    int v, hi, lo, h;
    logic set, clr;
    v = $signed(v16);
    hi = $signed(upper);
    lo = $signed(lower);
    h = int'(hyst);
    case (m)
      2'd0: {set, clr} = {v > hi, v < hi - h};
      2'd1: {set, clr} = {v < lo, v > lo + h};
      2'd2: {set, clr} = {v >= lo && v <= hi, v < lo - h || v > hi + h};
      default: {set, clr} = {v > hi || v < lo, v > lo + h && v < hi - h};
    endcase
    return set | (prev & ~clr);
  endfunction : thr_next

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("counts: checked %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // synchronous reset, then outputs must sit at their idle values
  task automatic do_reset(input int n);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    repeat (n) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    #1;
    chk(16'(dout), 16'h0000);
    chk(16'(ao_voltage), 16'h0001);
    chk(status, RST_WORD);
    alarm_exp = 1'b0;
  endtask : do_reset

  // write: request held for one taking edge
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge i_ref_clk);
    req.wr <= 1'b0;
  endtask : reg_wr

  // read: ack and data stand for the cycle after the taking edge
  task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge i_ref_clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge i_ref_clk);
    req.rd <= 1'b0;
    #1;
    chk(16'(ack), 16'h0001);
    chk(rdata, exp);
  endtask : reg_rd

  task automatic set_cfg(input logic [15:0] c, input logic [15:0] a);
    cfg = c;
    actl = a;
    reg_wr(ADDR_OUT_CFG, c);
    reg_wr(ADDR_ALARM_CTRL, a);
    reg_wr(ADDR_THR_HIGH, upper);
    reg_wr(ADDR_THR_LOW, lower);
    reg_wr(ADDR_HYST, hyst);
    reg_rd(ADDR_OUT_CFG, c);
    chk(16'(dout), {15'h0000, a[ACTL_INIT_CLOSED]});
  endtask : set_cfg

  // one sample step with expectations worked out beforehand
  task automatic do_sample(input logic [15:0] v, input fault_in_t f, input logic d);
    logic a_any, act, dexp, fa;
    logic [15:0] sc, aexp;
    sc = 16'($random(seed));
    alarm_exp = thr_next(cfg[11:10], v, alarm_exp);
    a_any = alarm_exp | (actl[ACTL_DIN_EN] & (d == actl[ACTL_DIN_LEVEL]));
    act = (actl[ACTL_ROUTE_DO] & a_any) | (|(actl[13:8] & f[5:0]));
    dexp = act ? actl[ACTL_CLOSED_ON] : ~actl[ACTL_CLOSED_ON];
    fa = (|(cfg[8:3] & f[5:0])) | (cfg[9] & a_any);
    aexp = fa ? (cfg[CFG_CURRENT] ? FAULT_LEVEL_UA : FAULT_LEVEL_MV) : sc;
    st_exp = {5'h00, f.sensor, f.eeprom, f.rtc, f.logging, f.hw, dexp, d, f.under, f.over, a_any,
      f.hw | f.logging | f.rtc | f.eeprom | f.sensor};
    @(posedge i_ref_clk);
    valid <= 1'b1;
    sample <= v;
    fault <= f;
    din_req <= d;
    scaled <= sc;
    @(posedge i_ref_clk);
    valid <= 1'b0;
    #1;
    chk(status, st_exp);
    chk(16'(dout), 16'(dexp));
    chk(16'(ao_force), 16'(fa));
    chk(ao_value, aexp);
    chk(16'(ao_voltage), {15'h0000, ~cfg[CFG_CURRENT]});
    // the field side sees the level and the contact one clock later
    @(posedge i_ref_clk);
    #1;
    chk(load, aexp);
    chk(16'(relay), 16'(dexp));
  endtask : do_sample

  initial begin
    logic [31:0] r;
    seed = 32'h30b8;
    i_rst_n = 1'b0;
    req = '0;
    valid = 1'b0;
    sample = 16'h0000;
    scaled = 16'h0000;
    fault = '0;
    din_req = 1'b0;
    bad_count = 0;
    checked = 0;
    upper = 16'h0064;
    lower = 16'hFF9C;
    hyst = 16'h0014;
    do_reset(20);
    // register map: reset values, read-only status, unmapped place, sensor codes
    reg_rd(ADDR_SENSOR_TYPE, RST_SENSOR_TYPE);
    reg_rd(ADDR_OUT_CFG, RST_OUT_CFG);
    reg_wr(ADDR_STATUS, 16'hFFFF);
    reg_rd(ADDR_STATUS, RST_WORD);
    reg_rd(16'h0100, 16'h0000);
    foreach (codes[i]) begin
      reg_wr(ADDR_SENSOR_TYPE, codes[i]);
      reg_rd(ADDR_SENSOR_TYPE, codes[i]);
    end
    $display("test registers done");
    // every mode twice, with random routing and enables, polarity and output kind set from the pass count
    for (int m = 0; m < 8; m++) begin
      do_reset(2);
      r = $random(seed);
      set_cfg({4'h0, 2'(m), r[9:1], m[2]}, {2'b00, r[21:16], 5'b00000, r[22], m[2], r[24] | m[0]});
      for (int i = 0; i < 40; i++) begin
        do_sample(i < 10 ? 16'(corner[i]) : 16'($random(seed) % 300),
          fault_in_t'(7'($random(seed) & $random(seed))), 1'($random(seed)));
      end
      reg_rd(ADDR_STATUS, st_exp);
    end
    $display("test threshold modes done");
    // alarm tied to the high digital input level, contact opens on alarm
    do_reset(2);
    set_cfg(16'h0000, 16'h0019);
    do_sample(16'h0000, '0, 1'b1);
    do_sample(16'h0000, '0, 1'b0);
    do_sample(16'h0000, '0, 1'b1);
    $display("test digital input done");
    // manual mode: outputs follow the written registers, no forcing
    set_cfg(16'h13F9, 16'h0000);
    reg_wr(ADDR_OUT_VALUE, 16'h1234);
    reg_wr(ADDR_MANUAL_DO, 16'h0001);
    @(posedge i_ref_clk);
    #1;
    chk(ao_value, 16'h1234);
    chk(16'(dout), 16'h0001);
    chk(16'(ao_force), 16'h0000);
    reg_rd(ADDR_OUT_VALUE, 16'h1234);
    $display("test manual mode done");
    final_report();
  end
endmodule : tb
